// ===== core/bridge_cfg_pkg.sv
// Overview of operation
// - command bit 0 enables response to primary I/O; resets to zero.
// - command bit 1 enables response to primary memory; resets to zero.
// - bit 2 clear blocks primary mastering and secondary memory/I/O response.
// - command bits 3 and 7 are read-only zero; no stepping performed.
// - command bit 4 is read-only zero.
// - bit 5 claims I/O writes at 3C6h/3C8h/3C9h, bits 15:10 ignored.
// - bit 6 enables normal parity-error action; resets to zero.
// - bit 8 gates the primary system-error driver; resets to zero.
// - bit 9 permits fast back-to-back initiation; resets to zero.
// - command bits 15:10 read as zero.
// - status bit 20 reads one, capability list present.
// - status bit 21 reads one, 66MHz capable.
// - status bit 23 reads one, fast back-to-back decode capable.
// - status field 26:25 reads 01, medium select timing.
// - status bit 24 set on master data parity error while bit 6 is set; resets zero.
// - status bit 27 set on signalled target abort; resets zero.
// - status bit 28 set on received target abort; resets zero.
// - status bit 29 set on received master abort; resets zero.
// - status bit 30 set when system-error output is asserted.
// - status bit 31 set on any primary address or data parity error.
// - upper half of dword zero holds read-only 16-bit device code.
// - sticky flags clear only by writing one; zero leaves them.
package bridge_cfg_pkg;

  localparam logic [7:0] OFS_ID = 8'h00;
  localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
  localparam logic [7:0] OFS_REVISION = 8'h08;

  localparam int CMD_IO_EN = 0;
  localparam int CMD_MEM_EN = 1;
  localparam int CMD_MASTER_EN = 2;
  localparam int CMD_VGA_SNOOP = 5;
  localparam int CMD_PERR_RESP = 6;
  localparam int CMD_SERR_EN = 8;
  localparam int CMD_FBB_EN = 9;

  localparam logic [15:0] CMD_WRITE_MASK = 16'h0367;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // capability list, 66MHz, fast back-to-back, medium select timing
  localparam logic [15:0] STATUS_FIXED = 16'h02b0;

  localparam int NUM_FLAGS = 6;
  localparam int FLAG_MASTER_DPERR = 0;
  localparam int FLAG_SIG_TABORT = 1;
  localparam int FLAG_RCV_TABORT = 2;
  localparam int FLAG_RCV_MABORT = 3;
  localparam int FLAG_SIG_SERR = 4;
  localparam int FLAG_DET_PERR = 5;
  // position of each flag within the status half
  localparam int FLAG_POS [NUM_FLAGS] = '{8, 11, 12, 13, 14, 15};
  localparam logic FLAG_RESET = 1'b0;

  localparam logic [9:0] VGA_PAL_MASK = 10'h3c6;
  localparam logic [9:0] VGA_PAL_READ = 10'h3c8;
  localparam logic [9:0] VGA_PAL_DATA = 10'h3c9;

  typedef struct packed {
    logic sel;
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic master_data_perr;
    logic target_abort_sent;
    logic target_abort_rcvd;
    logic master_abort_rcvd;
    logic addr_perr;
    logic data_perr;
    logic serr_request;
  } bus_event_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
  } io_probe_s;

  typedef struct packed {
    logic io_respond;
    logic mem_respond;
    logic master_primary;
    logic secondary_respond;
    logic perr_action;
    logic fast_b2b;
  } enables_s;

endpackage

// ===== core/sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag
  import bridge_cfg_pkg::*;
(
  // clock and control
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // set and clear
  input wire logic set,
  input wire logic clear,
  // state
  output logic flag
);

  // set is checked first so an event is never lost to a clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flag <= FLAG_RESET;
    end else if (ce) begin
      if (set) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end

  a_flag_set_wins: assert property (
    @(posedge core_clk) disable iff (srst) ce && set |=> flag)
    else $error("flag not set after event");

endmodule // sticky_flag

// ===== core/bridge_primary_cmd_status.sv
`timescale 1ns/1ps
module bridge_primary_cmd_status
  import bridge_cfg_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [15:0] DEVICE_CODE = 16'h5a17,
  parameter logic [7:0] REVISION_CODE = 8'h01
)
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // configuration access
  input wire cfg_req_s cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // events from the bridge datapath
  input wire bus_event_s bus_event,
  // primary I/O cycle probe for palette snooping
  input wire io_probe_s io_probe,
  output logic vga_claim,
  // command enables to the datapath
  output enables_s enables,
  // primary system error, open drain
  output logic primary_system_error_n,
  output logic primary_system_error_oe
);

  logic [15:0] command;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clear;
  logic [15:0] status;
  logic cmd_write;
  logic status_write;
  logic vga_hit;
  logic [31:0] next_rdata;

  assign cmd_write = cfg_req.sel && cfg_req.we &&
                     cfg_req.addr[7:2] == OFS_CMD_STATUS[7:2];
  assign status_write = cmd_write && cfg_req.be[3];

  // command register: only the documented enables can be written
  always_ff @(posedge core_clk) begin
    if (srst) begin
      command <= CMD_RESET;
    end else if (ce && cmd_write) begin
      if (cfg_req.be[0]) begin
        command[7:0] <= cfg_req.wdata[7:0] & CMD_WRITE_MASK[7:0];
      end
      if (cfg_req.be[1]) begin
        command[15:8] <= cfg_req.wdata[15:8] & CMD_WRITE_MASK[15:8];
      end
    end
  end

  // enables straight from command flops
  always_comb begin
    enables.io_respond = command[CMD_IO_EN];
    enables.mem_respond = command[CMD_MEM_EN];
    enables.master_primary = command[CMD_MASTER_EN];
    enables.secondary_respond = command[CMD_MASTER_EN];
    enables.perr_action = command[CMD_PERR_RESP];
    enables.fast_b2b = command[CMD_FBB_EN];
  end

  // palette snoop: only the low ten bits decode, ISA aliases included
  assign vga_hit = io_probe.valid && io_probe.write &&
                   (io_probe.addr[9:0] == VGA_PAL_MASK ||
                    io_probe.addr[9:0] == VGA_PAL_READ ||
                    io_probe.addr[9:0] == VGA_PAL_DATA);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      vga_claim <= 1'b0;
    end else if (ce) begin
      vga_claim <= vga_hit && command[CMD_VGA_SNOOP];
    end
  end

  // system error driver: pin pulled low only while enabled
  assign primary_system_error_n = 1'b0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      primary_system_error_oe <= 1'b0;
    end else if (ce) begin
      primary_system_error_oe <= bus_event.serr_request &&
                                 command[CMD_SERR_EN];
    end
  end

  // flag sources; master data parity only counts with parity response on
  always_comb begin
    flag_set = '0;
    flag_set[FLAG_MASTER_DPERR] = bus_event.master_data_perr &&
                                  command[CMD_PERR_RESP];
    flag_set[FLAG_SIG_TABORT] = bus_event.target_abort_sent;
    flag_set[FLAG_RCV_TABORT] = bus_event.target_abort_rcvd;
    flag_set[FLAG_RCV_MABORT] = bus_event.master_abort_rcvd;
    flag_set[FLAG_SIG_SERR] = primary_system_error_oe;
    flag_set[FLAG_DET_PERR] = bus_event.addr_perr ||
                              bus_event.data_perr;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      // write one to clear, byte lane 3 only
      assign flag_clear[gi] = status_write &&
                              cfg_req.wdata[16 + FLAG_POS[gi]];
      sticky_flag u_flag (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .set(flag_set[gi]),
        .clear(flag_clear[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  always_comb begin
    status = STATUS_FIXED;
    for (int i = 0; i < NUM_FLAGS; i++) begin
      status[FLAG_POS[i]] = flags[i];
    end
  end

  // read mux; offsets outside this block read zero
  always_comb begin
    next_rdata = '0;
    case (cfg_req.addr[7:2])
      OFS_ID[7:2]: next_rdata = {DEVICE_CODE, 16'h0000};
      OFS_CMD_STATUS[7:2]: next_rdata = {status, command};
      OFS_REVISION[7:2]: next_rdata = {24'h000000, REVISION_CODE};
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_ack <= 1'b0;
    end else if (ce) begin
      cfg_ack <= cfg_req.sel;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_rdata <= '0;
    end else if (ce && cfg_req.sel && !cfg_req.we) begin
      cfg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_cmd_reset_zero: assert property (
    $past(srst) |-> command == CMD_RESET)
    else $error("command not zero after reset");

  a_cmd_ro_zero: assert property (
    (command & ~CMD_WRITE_MASK) == 16'h0000)
    else $error("read-only command bits not zero");

  a_cmd_high_zero: assert property (
    ce && cfg_req.sel && !cfg_req.we && cfg_req.addr == OFS_CMD_STATUS
    |=> cfg_rdata[15:10] == 6'h00 && cfg_rdata[4] == 1'b0)
    else $error("command upper bits read nonzero");

  a_status_fixed: assert property (
    ce && cfg_req.sel && !cfg_req.we && cfg_req.addr == OFS_CMD_STATUS
    |=> (cfg_rdata[31:16] & 16'h06ff) == STATUS_FIXED)
    else $error("fixed status bits wrong");

  a_status_flags: assert property (
    ce && cfg_req.sel && !cfg_req.we && cfg_req.addr == OFS_CMD_STATUS
    |=> cfg_rdata[31:24] ==
        {$past(flags[5:1]), 2'b01, $past(flags[0])})
    else $error("status flags read wrong");

  a_io_enable_out: assert property (
    ce && cmd_write && cfg_req.be[0]
    |=> enables.io_respond == $past(cfg_req.wdata[0]))
    else $error("io enable not written");

  a_mem_enable_out: assert property (
    ce && cmd_write && cfg_req.be[0]
    |=> enables.mem_respond == $past(cfg_req.wdata[1]))
    else $error("memory enable not written");

  a_master_enable_out: assert property (
    ce && cmd_write && cfg_req.be[0]
    |=> enables.master_primary == $past(cfg_req.wdata[2]) &&
        enables.secondary_respond == $past(cfg_req.wdata[2]))
    else $error("master enable not written");

  a_perr_enable_out: assert property (
    ce && cmd_write && cfg_req.be[0]
    |=> enables.perr_action == $past(cfg_req.wdata[6]))
    else $error("parity response not written");

  a_fbb_enable_out: assert property (
    ce && cmd_write && cfg_req.be[1]
    |=> enables.fast_b2b == $past(cfg_req.wdata[9]))
    else $error("fast back-to-back enable not written");

  a_cmd_held: assert property (
    !(ce && cmd_write) |=> command == $past(command))
    else $error("command changed without a write");

  a_vga_claim: assert property (
    ce && vga_hit && command[CMD_VGA_SNOOP] |=> vga_claim)
    else $error("palette write not claimed");

  a_vga_alias: assert property (
    ce && command[CMD_VGA_SNOOP] && io_probe.valid && io_probe.write &&
    io_probe.addr[9:0] == VGA_PAL_DATA |=> vga_claim)
    else $error("aliased palette write not claimed");

  a_vga_ignore: assert property (
    ce && !command[CMD_VGA_SNOOP] |=> !vga_claim)
    else $error("palette claimed while snoop off");

  a_vga_read_ignored: assert property (
    ce && !io_probe.write |=> !vga_claim)
    else $error("palette read claimed");

  a_serr_gated: assert property (
    ce && !command[CMD_SERR_EN] |=> !primary_system_error_oe)
    else $error("system error driven while disabled");

  a_serr_follows: assert property (
    ce && bus_event.serr_request && command[CMD_SERR_EN]
    |=> primary_system_error_oe)
    else $error("system error not driven");

  a_serr_flag: assert property (
    ce && primary_system_error_oe |=> flags[FLAG_SIG_SERR])
    else $error("system error flag not set");

  a_serr_flag_only: assert property (
    ce && !primary_system_error_oe && !flags[FLAG_SIG_SERR]
    |=> !flags[FLAG_SIG_SERR])
    else $error("system error flag set without the driver");

  a_perr_any_role: assert property (
    ce && (bus_event.addr_perr || bus_event.data_perr)
    |=> flags[FLAG_DET_PERR])
    else $error("parity flag missed");

  a_mdperr_set: assert property (
    ce && bus_event.master_data_perr && command[CMD_PERR_RESP]
    |=> flags[FLAG_MASTER_DPERR])
    else $error("master parity flag missed");

  a_mdperr_refused: assert property (
    ce && !command[CMD_PERR_RESP] && !flags[FLAG_MASTER_DPERR]
    |=> !flags[FLAG_MASTER_DPERR])
    else $error("master parity flag set while response off");

  a_tabort_sent: assert property (
    ce && bus_event.target_abort_sent |=> flags[FLAG_SIG_TABORT])
    else $error("signalled target abort missed");

  a_tabort_rcvd: assert property (
    ce && bus_event.target_abort_rcvd |=> flags[FLAG_RCV_TABORT])
    else $error("received target abort missed");

  a_mabort_rcvd: assert property (
    ce && bus_event.master_abort_rcvd |=> flags[FLAG_RCV_MABORT])
    else $error("received master abort missed");

  a_flags_reset: assert property (
    $past(srst) |-> flags == {NUM_FLAGS{FLAG_RESET}})
    else $error("flags not clear after reset");

  a_w1c_clear: assert property (
    ce && status_write && cfg_req.wdata[31] && !flag_set[FLAG_DET_PERR]
    |=> !flags[FLAG_DET_PERR])
    else $error("write one did not clear flag");

  a_zero_keeps: assert property (
    ce && status_write && !cfg_req.wdata[29] && flags[FLAG_RCV_MABORT]
    |=> flags[FLAG_RCV_MABORT])
    else $error("write zero cleared flag");

  a_flag_sticky: assert property (
    ce && !status_write |=> (flags & $past(flags)) == $past(flags))
    else $error("flag dropped without a clear");

  a_devid_read: assert property (
    ce && cfg_req.sel && !cfg_req.we && cfg_req.addr == OFS_ID
    |=> cfg_ack && cfg_rdata[31:16] == DEVICE_CODE)
    else $error("device code read wrong");

  c_flag_cleared: cover property (
    flags[FLAG_RCV_TABORT] ##1 ce && status_write ##1
    !flags[FLAG_RCV_TABORT]);
  c_vga_claimed: cover property (vga_claim);
  c_serr_driven: cover property (primary_system_error_oe);
  c_set_and_clear: cover property (ce && flag_set[FLAG_RCV_TABORT] &&
    flag_clear[FLAG_RCV_TABORT]);

endmodule // bridge_primary_cmd_status

// ===== testbench/pci_side_model.sv
`timescale 1ns/1ps
module pci_side_model
  import bridge_cfg_pkg::*;
(
  // clock
  input wire logic core_clk,
  // toward the block
  output bus_event_s bus_event,
  output io_probe_s io_probe
);
  initial begin
    bus_event = '0;
    io_probe = '{1'b0, 1'b1, 16'hffff};
  end
  // one-cycle event, bit k of the packed event struct
  task automatic pulse(input int k);
    @(posedge core_clk); #2;
    bus_event = bus_event_s'(7'h01 << k);
    @(posedge core_clk); #2;
    bus_event = '0;
  endtask
  // released probe lines show the inverse, never the last value
  task automatic probe(input logic w, input logic [15:0] a);
    @(posedge core_clk); #2;
    io_probe = '{1'b1, w, a};
    @(posedge core_clk); #2;
    io_probe = '{1'b0, ~w, ~a};
  endtask
endmodule // pci_side_model

// ===== testbench/bridge_primary_cmd_status_tb.sv
`timescale 1ns/1ps
module bridge_primary_cmd_status_tb
  import bridge_cfg_pkg::*;
;
  logic core_clk, srst, ce, cfg_ack, vga_claim, serr_n, serr_oe;
  logic [31:0] cfg_rdata, d, m;
  logic [15:0] c;
  logic [63:0] note;
  logic [63:0] notes [$];
  cfg_req_s cfg_req;
  bus_event_s bus_event;
  io_probe_s io_probe;
  enables_s enables;
  int mismatches = 0, n_compared = 0, seed = 12, k, i;
  // status bit hit by each event, index = bit of the event struct
  int bitpos [7] = '{30, 31, 31, 29, 28, 27, 24};
  logic [9:0] lows [4] = '{10'h3c6, 10'h3c8, 10'h3c9, 10'h3c5};

  // arbitrary identity values, handed to the block and expected back
  localparam logic [15:0] DEVICE_CODE = 16'h3c5e;
  localparam logic [7:0] REVISION_CODE = 8'h2d;

  bridge_primary_cmd_status #(.DEVICE_CODE(DEVICE_CODE),
    .REVISION_CODE(REVISION_CODE)) dut (.core_clk(core_clk), .srst(srst),
    .ce(ce),
    .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .bus_event(bus_event), .io_probe(io_probe), .vga_claim(vga_claim),
    .enables(enables), .primary_system_error_n(serr_n),
    .primary_system_error_oe(serr_oe));
  pci_side_model model (.core_clk(core_clk), .bus_event(bus_event),
    .io_probe(io_probe));

  always #25 core_clk = ~core_clk;

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one access; the note holds {mask, expected read data}
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] wd, input logic [31:0] mk, input logic [31:0] e);
    int n;
    @(posedge core_clk); #2;
    cfg_req = '{1'b1, w, a, b, wd};
    notes.push_back({mk, e});
    @(posedge core_clk); #2;
    cfg_req.sel = 1'b0;
    n = 0;
    while (cfg_ack !== 1'b1 && n < 3) begin
      @(posedge core_clk); #2;
      n++;
    end
    if (n == 3) begin
      mismatches++;
      give_verdict();
    end
  endtask

  task automatic rst();
    srst = 1'b1;
    repeat (4) @(posedge core_clk);
    #2;
    srst = 1'b0;
  endtask

  task automatic basics();
    cfg(1'b1, OFS_ID, 4'hf, 32'hffffffff, 32'h0, 32'h0);
    cfg(1'b0, OFS_ID, 4'h0, 32'h0, 32'hffff0000, {DEVICE_CODE, 16'h0});
    cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, 32'hffffffff,
      {STATUS_FIXED, CMD_RESET});
    cfg(1'b0, OFS_REVISION, 4'h0, 32'h0, 32'hff, {24'h0, REVISION_CODE});
    cfg(1'b0, 8'h0c, 4'h0, 32'h0, 32'hffffffff, 32'h0);
  endtask

  always @(posedge core_clk) begin
    #1;
    if (cfg_ack === 1'b1) begin
      if (notes.size() == 0) chk(32'h1, 32'h0);
      else begin
        note = notes.pop_front();
        chk(cfg_rdata & note[63:32], note[31:0] & note[63:32]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    core_clk = 1'b0;
    ce = 1'b1;
    cfg_req = '0;
    rst();
    basics();
    // system error while its driver is disabled
    model.pulse(0);
    chk({31'h0, serr_oe}, 32'h0);
    cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, 32'h40000000, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      c = d[15:0] & CMD_WRITE_MASK;
      cfg(1'b1, OFS_CMD_STATUS, 4'h3, d, 32'h0, 32'h0);
      cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, 32'hffff, {16'h0, c});
      chk({26'h0, enables}, {26'h0, c[0], c[1], c[2], c[2], c[6], c[9]});
    end
    cfg(1'b1, OFS_CMD_STATUS, 4'h3, 32'hffff, 32'h0, 32'h0);
    for (k = 0; k < 7; k++) begin
      model.pulse(k);
      if (k == 0) chk({31'h0, serr_oe}, 32'h1);
      if (k == 0) chk({31'h0, serr_n}, 32'h0);
      m = 32'h1 << bitpos[k];
      cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, m, m);
      cfg(1'b1, OFS_CMD_STATUS, 4'h7, 32'hffffffff, 32'h0, 32'h0);
      cfg(1'b1, OFS_CMD_STATUS, 4'h8, 32'h0, 32'h0, 32'h0);
      cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, m, m);
      cfg(1'b1, OFS_CMD_STATUS, 4'h8, m, 32'h0, 32'h0);
      cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, m, 32'h0);
    end
    // set and clear meeting at one edge
    fork
      model.pulse(4);
      cfg(1'b1, OFS_CMD_STATUS, 4'h8, 32'h10000000, 32'h0, 32'h0);
    join
    cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, 32'h10000000, 32'h10000000);
    // master parity error refused while parity response is off
    cfg(1'b1, OFS_CMD_STATUS, 4'h3, 32'h20, 32'h0, 32'h0);
    model.pulse(6);
    cfg(1'b0, OFS_CMD_STATUS, 4'h0, 32'h0, 32'h01000000, 32'h0);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      model.probe(1'b1, {d[5:0], lows[i]});
      chk({31'h0, vga_claim}, {31'h0, i < 3});
    end
    model.probe(1'b0, 16'hfbc6);
    chk({31'h0, vga_claim}, 32'h0);
    cfg(1'b1, OFS_CMD_STATUS, 4'h3, 32'h0, 32'h0, 32'h0);
    model.probe(1'b1, 16'h03c8);
    chk({31'h0, vga_claim}, 32'h0);
    // second reset in mid-run clears a standing flag
    cfg(1'b1, OFS_CMD_STATUS, 4'h3, 32'h0367, 32'h0, 32'h0);
    model.pulse(3);
    rst();
    basics();
    chk({26'h0, enables}, 32'h0);
    repeat (2) @(posedge core_clk);
    give_verdict();
  end
endmodule // bridge_primary_cmd_status_tb
